// >>> verilog/stf_pkg.sv
// Package with constants and carrier types of the stable time filter.
package stf_pkg;
    // Clock and time base.
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // Stable time is kept in tenths of a second, monitoring time in seconds.
    localparam int MS_PER_TENTH = 100;
    localparam int MS_PER_SEC = 1000;
    localparam logic [4:0] STABLE_MIN = 5'h01;
    localparam logic [4:0] STABLE_MAX = 5'h14;
    localparam logic [4:0] MONITOR_MIN = 5'h01;
    localparam logic [4:0] MONITOR_MAX = 5'h14;
    // Defaults for solid-state switch outputs and for dry contacts.
    localparam logic [4:0] STABLE_SOLID = 5'h01;
    localparam logic [4:0] STABLE_DRY = 5'h07;
    localparam logic [4:0] MONITOR_SOLID = 5'h02;
    localparam logic [4:0] MONITOR_DRY = 5'h0a;
    localparam logic DUAL_DEFAULT = 1'b1;
    localparam logic CROSS_DEFAULT = 1'b0;
    localparam logic TWO_WIRE_DEFAULT = 1'b0;
    // Test pulses in milliseconds: width, interval and offset of channel b.
    localparam logic [8:0] TP_WIDTH_MS = 9'h001;
    localparam logic [8:0] TP_PERIOD_MS = 9'h1f4;
    localparam logic [8:0] TP_B_OFFSET_MS = 9'h0fa;
    localparam int STABLE_W = 11;
    localparam int WINDOW_W = 15;

    typedef enum logic [1:0] {
        STF_IDLE = 2'b00,
        STF_MON = 2'b01,
        STF_ON = 2'b10,
        STF_FAULT = 2'b11
    } stf_state_t;

    typedef struct packed {
        logic dual_channel;
        logic cross_fault_on;
        logic two_wire;
        logic use_default;
        logic [4:0] stable_tenths;
        logic [4:0] monitor_sec;
    } stf_cfg_t;

    typedef struct packed {
        logic safety_enable;
        logic out_do;
        logic out_y1;
        logic fault;
        logic cross_fault;
        logic window_running;
    } stf_status_t;
endpackage

// >>> verilog/stf_filter.sv
// Stable time filter with discrepancy monitoring for one safety device port.
`timescale 1ns/1ns
// Notes on behaviour
// - Port selects single or dual channel, default dual.
// - Cross-fault monitoring on/off per port, default off.
// - Output driven one wire or two, default one.
// - Dual: first contact on starts monitoring window.
// - Dual: both on for stable time enables.
// - Dual: unsettled or dropped contact faults at expiry.
// - Single: debounce input, first on starts window.
// - Single: on for stable time enables safety.
// - Single: unsettled contact faults at window expiry.
// - Release delayed only by the stable time.
// - Stable time 0.1 to 2.0 s, defaults.
// - Monitoring time 1 to 20 s, defaults.
// - Cross-fault mode feeds 1 ms pulses every 500 ms.
// - Fault holds until cause gone and acknowledged.
module stf_filter #(
    parameter int TICK_CYCLES = stf_pkg::TICK_CYCLES // Clock cycles per millisecond tick.
) (
    input wire logic core_clk, // Module clock, 250 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic cfg_load, // One-cycle strobe taking cfg_in.
    input wire stf_pkg::stf_cfg_t cfg_in, // New port settings.
    input wire logic contact_a, // First safety input, high when on.
    input wire logic contact_b, // Second safety input, high when on.
    input wire logic fault_ack, // One-cycle fault acknowledge.
    output stf_pkg::stf_cfg_t cfg, // Settings in force.
    output stf_pkg::stf_status_t status, // Enable, outputs and faults.
    output logic supply_a, // Test pulse output feeding contact a.
    output logic supply_b // Test pulse output feeding contact b.
);
    // The divider needs one idle cycle between ticks, so shorter periods are refused.
    if (TICK_CYCLES < 2) begin : tick_range_check
        $error("TICK_CYCLES must be at least 2");
    end

    // Bring a requested time into its legal range.
    function automatic logic [4:0] clamp(input logic [4:0] v, input logic [4:0] lo,
                                         input logic [4:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    stf_pkg::stf_state_t state;
    logic [31:0] div_cnt;
    logic tick;
    logic [8:0] tp_cnt;
    logic hold_a;
    logic hold_b;
    logic ev_a;
    logic ev_b;
    logic all_on;
    logic any_on;
    logic cross_err;
    logic [stf_pkg::STABLE_W-1:0] stable_cnt;
    logic [stf_pkg::WINDOW_W-1:0] win_cnt;
    logic [stf_pkg::STABLE_W-1:0] stable_target;
    logic [stf_pkg::WINDOW_W-1:0] window_target;
    logic stable_done;
    logic window_done;

    // Millisecond enable; long counts live here so that timing is cheap to scale.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (div_cnt == 32'(TICK_CYCLES - 1)) begin
            div_cnt <= 32'h0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // Settings: reset defaults, clamped loads, presets on request (dry-contact with cross-fault on, solid-state otherwise).
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg.dual_channel <= stf_pkg::DUAL_DEFAULT;
            cfg.cross_fault_on <= stf_pkg::CROSS_DEFAULT;
            cfg.two_wire <= stf_pkg::TWO_WIRE_DEFAULT;
            cfg.use_default <= 1'b1;
            cfg.stable_tenths <= stf_pkg::STABLE_SOLID;
            cfg.monitor_sec <= stf_pkg::MONITOR_SOLID;
        end else if (cfg_load) begin
            cfg.dual_channel <= cfg_in.dual_channel;
            cfg.cross_fault_on <= cfg_in.cross_fault_on;
            cfg.two_wire <= cfg_in.two_wire;
            cfg.use_default <= cfg_in.use_default;
            if (cfg_in.use_default) begin
                cfg.stable_tenths <= cfg_in.cross_fault_on ? stf_pkg::STABLE_DRY
                                                           : stf_pkg::STABLE_SOLID;
                cfg.monitor_sec <= cfg_in.cross_fault_on ? stf_pkg::MONITOR_DRY
                                                         : stf_pkg::MONITOR_SOLID;
            end else begin
                cfg.stable_tenths <= clamp(cfg_in.stable_tenths, stf_pkg::STABLE_MIN,
                                           stf_pkg::STABLE_MAX);
                cfg.monitor_sec <= clamp(cfg_in.monitor_sec, stf_pkg::MONITOR_MIN,
                                         stf_pkg::MONITOR_MAX);
            end
        end
    end

    // Test pulses are staggered so that a short between the two lines shows up.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tp_cnt <= 9'h0;
            supply_a <= 1'b1;
            supply_b <= 1'b1;
        end else begin
            if (tick) begin
                tp_cnt <= (tp_cnt == stf_pkg::TP_PERIOD_MS - 9'h1) ? 9'h0 : tp_cnt + 9'h1;
            end
            supply_a <= !(cfg.cross_fault_on && tp_cnt < stf_pkg::TP_WIDTH_MS);
            supply_b <= !(cfg.cross_fault_on && tp_cnt >= stf_pkg::TP_B_OFFSET_MS &&
                          tp_cnt < stf_pkg::TP_B_OFFSET_MS + stf_pkg::TP_WIDTH_MS);
        end
    end

    // Last value seen outside a pulse, so the pulse itself is not taken as a switch-off.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_a <= 1'b0;
            hold_b <= 1'b0;
        end else begin
            if (supply_a) begin
                hold_a <= contact_a;
            end
            if (supply_b) begin
                hold_b <= contact_b;
            end
        end
    end

    // Evaluated contacts; channel b is ignored in single-channel mode.
    always_comb begin
        ev_a = supply_a ? contact_a : hold_a;
        ev_b = supply_b ? contact_b : hold_b;
        all_on = ev_a && (ev_b || !cfg.dual_channel);
        any_on = ev_a || (ev_b && cfg.dual_channel);
        // A line still high at the end of its own pulse is fed from elsewhere.
        cross_err = cfg.cross_fault_on && tick &&
                    ((!supply_a && contact_a) || (!supply_b && contact_b && cfg.dual_channel));
        stable_target = stf_pkg::STABLE_W'(cfg.stable_tenths * stf_pkg::MS_PER_TENTH);
        window_target = stf_pkg::WINDOW_W'(cfg.monitor_sec * stf_pkg::MS_PER_SEC);
        stable_done = tick && all_on && (stable_cnt + 1'b1 >= stable_target);
        window_done = tick && (win_cnt + 1'b1 >= window_target);
    end

    // Filter sequence; the stable check wins over expiry in the same tick.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= stf_pkg::STF_IDLE;
            stable_cnt <= '0;
            win_cnt <= '0;
        end else if (cross_err) begin
            state <= stf_pkg::STF_FAULT;
        end else begin
            unique case (state)
                stf_pkg::STF_IDLE: begin
                    stable_cnt <= '0;
                    win_cnt <= '0;
                    if (any_on && !cfg_load) begin
                        state <= stf_pkg::STF_MON;
                    end
                end
                stf_pkg::STF_MON: begin
                    if (cfg_load) begin
                        state <= stf_pkg::STF_IDLE;
                    end else if (stable_done) begin
                        state <= stf_pkg::STF_ON;
                    end else if (window_done) begin
                        state <= stf_pkg::STF_FAULT;
                    end else if (tick) begin
                        win_cnt <= win_cnt + 1'b1;
                        // A dropout seen at a millisecond tick, even a single one, restarts the stable count.
                        stable_cnt <= all_on ? stable_cnt + 1'b1 : '0;
                    end
                end
                stf_pkg::STF_ON: begin
                    if (!all_on || cfg_load) begin
                        state <= stf_pkg::STF_IDLE;
                    end
                end
                stf_pkg::STF_FAULT: begin
                    if (fault_ack && !any_on) begin
                        state <= stf_pkg::STF_IDLE;
                    end
                end
            endcase
        end
    end

    // Outputs follow the state; the sticky cross flag clears with the fault.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else begin
            status.safety_enable <= (state == stf_pkg::STF_ON);
            status.out_do <= (state == stf_pkg::STF_ON);
            status.out_y1 <= (state == stf_pkg::STF_ON) && cfg.two_wire;
            status.fault <= (state == stf_pkg::STF_FAULT);
            status.window_running <= (state == stf_pkg::STF_MON);
            if (cross_err) begin
                status.cross_fault <= 1'b1;
            end else if (state != stf_pkg::STF_FAULT) begin
                status.cross_fault <= 1'b0;
            end
        end
    end

    sequence s_first_on;
        state == stf_pkg::STF_IDLE && any_on && !cfg_load && !cross_err;
    endsequence
    sequence s_window_zero;
        state == stf_pkg::STF_MON && win_cnt == '0;
    endsequence

    window_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_first_on |=> s_window_zero) else $error("window did not start");
    release_cause_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state == stf_pkg::STF_ON) |-> $past(stable_done) && $past(all_on))
        else $error("release without stable time");
    fault_cause_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state == stf_pkg::STF_FAULT) |-> $past(window_done) || $past(cross_err))
        else $error("fault without expiry");
    drop_safety_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == stf_pkg::STF_ON && !all_on |=> ##1 !status.safety_enable)
        else $error("safety not dropped");
    fault_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == stf_pkg::STF_FAULT && !(fault_ack && !any_on) |=> state == stf_pkg::STF_FAULT)
        else $error("fault left early");
    single_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !cfg.dual_channel |-> all_on == ev_a) else $error("channel b used");
    two_wire_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        status.out_y1 |-> $past(cfg.two_wire) && status.out_do)
        else $error("y1 driven in one-wire mode");
    stable_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg.stable_tenths >= stf_pkg::STABLE_MIN && cfg.stable_tenths <= stf_pkg::STABLE_MAX)
        else $error("stable time out of range");
    monitor_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg.monitor_sec >= stf_pkg::MONITOR_MIN && cfg.monitor_sec <= stf_pkg::MONITOR_MAX)
        else $error("monitoring time out of range");
    pulse_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !cfg.cross_fault_on ##1 !cfg.cross_fault_on |-> supply_a && supply_b)
        else $error("test pulse with cross check off");
    cross_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cross_err |=> state == stf_pkg::STF_FAULT && status.cross_fault)
        else $error("cross fault not latched");
    single_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!cfg.dual_channel) and s_first_on |-> ev_a) else $error("start without contact");
    single_release_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !cfg.dual_channel && state == stf_pkg::STF_MON && stable_done && !cross_err && !cfg_load
        |=> state == stf_pkg::STF_ON) else $error("single release missed");
    single_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state == stf_pkg::STF_MON && window_done && !stable_done && !cfg_load && !cross_err
        |=> state == stf_pkg::STF_FAULT) else $error("expiry missed");
    release_delay_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state == stf_pkg::STF_ON) |-> $past(stable_cnt) + 1'b1 >= $past(stable_target))
        else $error("release before stable time");
endmodule // stf_filter

// >>> verification/stf_switch_model.sv
// Model of a two-contact safety switch fed from the port supplies.
`timescale 1ns/1ns
module stf_switch_model (
    input wire logic closed_a, // Contact a mechanically closed.
    input wire logic closed_b, // Contact b mechanically closed.
    input wire logic short_a, // Wiring short that pulls input a high.
    input wire logic supply_a, // Feed of contact a.
    input wire logic supply_b, // Feed of contact b.
    output logic contact_a, // Level seen at input a.
    output logic contact_b // Level seen at input b.
);
    // A closed dry contact only passes its feed, so every test pulse shows at the input.
    // A short ignores the feed, which is exactly what the pulse check must catch.
    // Kept combinational so that a stimulus change and the contact never race on one edge.
    always_comb begin
        contact_a = (closed_a & supply_a) | short_a;
        contact_b = closed_b & supply_b;
    end
endmodule // stf_switch_model

// >>> verification/test_safety_input_stable_time_filter.sv
// Self-checking testbench of the stable time filter.
`timescale 1ns/1ns
module test_safety_input_stable_time_filter;
    localparam int TC = 2; // Short tick keeps 2 s windows inside the run.
    logic core_clk, rst_b, cfg_load, fault_ack, closed_a, closed_b, short_a;
    logic contact_a, contact_b, supply_a, supply_b;
    stf_pkg::stf_cfg_t cfg_in, cfg;
    stf_pkg::stf_status_t status;
    int errors, checks_done, n;
    stf_filter #(.TICK_CYCLES(TC)) stf_filter_inst (.core_clk(core_clk), .rst_b(rst_b),
        .cfg_load(cfg_load), .cfg_in(cfg_in), .contact_a(contact_a), .contact_b(contact_b),
        .fault_ack(fault_ack), .cfg(cfg), .status(status), .supply_a(supply_a),
        .supply_b(supply_b));
    stf_switch_model stf_switch_model_inst (.closed_a(closed_a),
        .closed_b(closed_b), .short_a(short_a), .supply_a(supply_a), .supply_b(supply_b),
        .contact_a(contact_a), .contact_b(contact_b));
    // Free-running module clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Compares one value and counts it.
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("Checks done %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    // Waits for enable (0), fault (1) or cross fault (2); n counts the cycles spent.
    task automatic wait_flag(input int which, input int lim);
        logic v;
        for (n = 0; n < lim; n++) begin
            v = which == 0 ? status.safety_enable : which == 1 ? status.fault : status.cross_fault;
            if (v === 1'b1) break;
            @(negedge core_clk);
        end
    endtask
    task automatic load(input logic [13:0] v, input logic [13:0] exp);
        cfg_in = v;
        cfg_load = 1'b1;
        cyc(1);
        cfg_load = 1'b0;
        cyc(1);
        chk("cfg", 16'(cfg), 16'(exp));
    endtask
    // Acknowledge with all contacts open; the fault flag must be gone one cycle later.
    task automatic ack_clear;
        closed_a = 1'b0;
        closed_b = 1'b0;
        short_a = 1'b0;
        cyc(4);
        fault_ack = 1'b1;
        cyc(1);
        fault_ack = 1'b0;
        cyc(1);
        chk("fault after ack", 16'({status.fault, status.cross_fault}), 16'h0000);
    endtask
    task automatic t_reset;
        chk("cfg reset", 16'(cfg), 16'h2422);
        chk("status reset", 16'(status), 16'h0000);
        chk("supplies reset", 16'({supply_a, supply_b}), 16'h0003);
    endtask
    // Both contacts close cleanly, then one drops and comes back.
    task automatic t_dual_ok;
        {closed_a, closed_b} = 2'b11;
        wait_flag(0, 260);
        chk("dual enable delay", 16'(n >= 190 && n <= 215), 16'h0001);
        chk("dual outputs", 16'({status.out_do, status.out_y1}), 16'h0002);
        chk("window done", 16'(status.window_running), 16'h0000);
        closed_a = 1'b0;
        cyc(1);
        chk("enable held", 16'(status.safety_enable), 16'h0001);
        cyc(1);
        chk("enable dropped", 16'(status.safety_enable), 16'h0000);
        cyc(20);
        closed_a = 1'b1;
        wait_flag(0, 260);
        chk("restart delay", 16'(n >= 190 && n <= 215), 16'h0001);
        {closed_a, closed_b} = 2'b00;
        cyc(4 * 100 * TC);
    endtask
    task automatic t_bounce;
        {closed_a, closed_b} = 2'b11;
        cyc(100);
        closed_b = 1'b0;
        cyc(10);
        closed_b = 1'b1;
        wait_flag(0, 260);
        chk("bounce enable delay", 16'(n >= 190 && n <= 215), 16'h0001);
        {closed_a, closed_b} = 2'b00;
        cyc(4 * 100 * TC);
    endtask
    // One contact only: the window runs out and the port faults.
    task automatic t_dual_one;
        closed_a = 1'b1;
        cyc(4);
        chk("window started", 16'(status.window_running), 16'h0001);
        wait_flag(1, 4300);
        chk("discrepancy time", 16'(n >= 3985 && n <= 4020), 16'h0001);
        chk("no enable", 16'(status.safety_enable), 16'h0000);
        fault_ack = 1'b1;
        cyc(1);
        fault_ack = 1'b0;
        cyc(3);
        chk("ack refused", 16'(status.fault), 16'h0001);
        ack_clear();
    endtask
    task automatic t_cfg;
        load(14'h081f, 14'h0834);
        load(14'h22a0, 14'h2281);
        load(14'h3400, 14'h34ea);
        load(14'h2400, 14'h2422);
    endtask
    // Single channel, two-wire output, 0.1 s stable time in a 1 s window.
    task automatic t_single;
        logic seen_en;
        load(14'h0821, 14'h0821);
        closed_a = 1'b1;
        wait_flag(0, 260);
        chk("single enable delay", 16'(n >= 190 && n <= 215), 16'h0001);
        chk("two wire outputs", 16'({status.out_do, status.out_y1}), 16'h0003);
        closed_a = 1'b0;
        cyc(4 * 100 * TC);
        seen_en = 1'b0;
        repeat (44) begin
            closed_a = 1'b1;
            cyc(40);
            seen_en |= status.safety_enable;
            closed_a = 1'b0;
            cyc(10);
        end
        chk("single fault", 16'({status.fault, seen_en}), 16'h0002);
        ack_clear();
    endtask
    // Test pulses with cross fault monitoring on, then a shorted input.
    task automatic t_cross;
        int lo;
        load(14'h3400, 14'h34ea);
        for (lo = 0; lo < 1100 && supply_a !== 1'b0; lo++) cyc(1);
        for (lo = 0; lo < 10 && supply_a === 1'b0; lo++) cyc(1);
        chk("pulse width", 16'(lo), 16'(TC));
        for (n = lo; n < 1100 && supply_a === 1'b1; n++) cyc(1);
        chk("pulse period", 16'(n), 16'(500 * TC));
        // Channel b pulses at its own offset, so a short between the lines stays visible.
        for (lo = 0; lo < 1100 && supply_b === 1'b1; lo++) cyc(1);
        chk("pulse b offset", 16'(lo), 16'(int'(stf_pkg::TP_B_OFFSET_MS) * TC));
        short_a = 1'b1;
        wait_flag(2, 1100);
        // The fault flag follows the state one cycle after the sticky cross flag.
        cyc(1);
        chk("cross fault", 16'({status.fault, status.cross_fault}), 16'h0003);
        ack_clear();
    endtask
    // Run cut short if anything hangs.
    initial begin
        cyc(40000);
        errors++;
        close_out();
    end
    initial begin
        errors = 0;
        checks_done = 0;
        rst_b = 1'b0;
        {cfg_load, fault_ack, closed_a, closed_b, short_a} = 5'h00;
        cfg_in = 14'h2400;
        cyc(6);
        rst_b = 1'b1;
        cyc(1);
        t_reset();
        t_dual_ok();
        t_bounce();
        t_dual_one();
        t_cfg();
        t_single();
        t_cross();
        close_out();
    end
endmodule // test_safety_input_stable_time_filter
